// ===== rtl/rio_remote_status.sv
// Remote discrete I/O status outputs and command gating
`timescale 1ns/100ps
module rio_remote_status (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic [rio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [rio_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [rio_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [rio_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic [rio_pkg::CMD_W-1:0]  par_cmd,
    input  wire logic [rio_pkg::PROG_W-1:0] par_prog,
    input  wire logic [rio_pkg::CMD_W-1:0]  opu_cmd,
    input  wire logic                       auto_mode,
    input  wire logic                       teach_mode,
    input  wire logic                       estop_active,
    input  wire logic                       door_open,
    input  wire logic                       at_home,
    input  wire logic                       motion_stopped,
    input  wire logic                       op_done,
    input  wire logic                       error_event,
    output logic                            st_reset,
    output logic                            st_pause,
    output logic                            st_run,
    output logic                            st_home,
    output logic [rio_pkg::PROG_W-1:0]      st_prog,
    output logic                            st_cal,
    output logic                            st_motor,
    output logic                            st_error,
    output logic                            st_estop,
    output logic                            st_door,
    output logic                            st_auto,
    output logic                            st_teach,
    output logic                            hold_exec,
    output logic                            motor_power_en
);
    rio_reg_if regs ();

    logic [rio_pkg::CTRL_W-1:0] ctrl;
    logic [rio_pkg::CMD_W-1:0]  par_rise;
    logic [rio_pkg::CMD_W-1:0]  opu_rise;
    logic [rio_pkg::PROG_W-1:0] prog_sel;
    logic [rio_pkg::CMD_W-1:0]  cmd;
    logic [rio_pkg::PROG_W-1:0] prog;
    logic [rio_pkg::STATUS_W-1:0] status_word;
    rio_pkg::rio_state_t        state;
    rio_pkg::rio_state_t        next_state;
    rio_pkg::rio_op_t           op;
    rio_pkg::rio_op_t           next_op;
    logic                       motor_on;
    logic                       err;
    logic                       par_ok;
    logic                       opu_ok;
    logic                       console_ok;
    logic                       bad_motion;

    rio_axil_slave u_axil (
        .mclk    (mclk),
        .rst     (rst),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .regs    (regs.bus)
    );

    // Command inputs pass through two flops before any edge or gate logic
    rio_sync_edge #(.W(rio_pkg::CMD_W)) u_par_sync (
        .mclk  (mclk),
        .rst   (rst),
        .din   (par_cmd),
        .level (),
        .rise  (par_rise)
    );

    rio_sync_edge #(.W(rio_pkg::CMD_W)) u_opu_sync (
        .mclk  (mclk),
        .rst   (rst),
        .din   (opu_cmd),
        .level (),
        .rise  (opu_rise)
    );

    rio_sync_edge #(.W(rio_pkg::PROG_W)) u_prog_sync (
        .mclk  (mclk),
        .rst   (rst),
        .din   (par_prog),
        .level (prog_sel),
        .rise  ()
    );

    // Register file
    assign status_word = {st_teach, st_auto, st_door, st_estop, st_error, st_motor, st_cal,
                          st_home, st_run, st_pause, st_reset, prog};
    assign regs.wr_ok  = (regs.wr_addr == rio_pkg::REG_CTRL) || (regs.wr_addr == rio_pkg::REG_STATUS)
                         || (regs.wr_addr == rio_pkg::REG_PROG);

    always_comb begin
        regs.rd_ok   = 1'b1;
        regs.rd_data = '0;
        unique case (regs.rd_addr)
            rio_pkg::REG_CTRL:   regs.rd_data[rio_pkg::CTRL_W-1:0]   = ctrl;
            rio_pkg::REG_STATUS: regs.rd_data[rio_pkg::STATUS_W-1:0] = status_word;
            rio_pkg::REG_PROG:   regs.rd_data[rio_pkg::PROG_W-1:0]   = prog;
            default:             regs.rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= rio_pkg::CTRL_RESET_VAL;
        end else if (regs.wr_en && regs.wr_addr == rio_pkg::REG_CTRL && regs.wr_strb[0]) begin
            ctrl <= regs.wr_data[rio_pkg::CTRL_W-1:0];
        end
    end

    // Acceptance of remote commands
    assign console_ok = auto_mode & ~teach_mode & ctrl[rio_pkg::CTRL_CONSOLE];
    assign par_ok     = console_ok & ctrl[rio_pkg::CTRL_SOURCE] & ctrl[rio_pkg::CTRL_CONFIGURED];
    assign opu_ok     = console_ok & ~ctrl[rio_pkg::CTRL_SOURCE];
    assign cmd        = (par_rise & {rio_pkg::CMD_W{par_ok}}) | (opu_rise & {rio_pkg::CMD_W{opu_ok}});
    assign bad_motion = (cmd[rio_pkg::CMD_HOME] | cmd[rio_pkg::CMD_CAL]) & ~motor_on;

    // Controller sequencing
    always_comb begin
        next_state = state;
        next_op    = op;
        unique case (state)
            rio_pkg::ST_RESET: begin
                if (!estop_active && !err && !bad_motion) begin
                    if (cmd[rio_pkg::CMD_START]) begin
                        next_state = rio_pkg::ST_RUN;
                        next_op    = rio_pkg::OP_PROG;
                    end else if (cmd[rio_pkg::CMD_HOME]) begin
                        next_state = rio_pkg::ST_RUN;
                        next_op    = rio_pkg::OP_HOME;
                    end else if (cmd[rio_pkg::CMD_CAL]) begin
                        next_state = rio_pkg::ST_RUN;
                        next_op    = rio_pkg::OP_CAL;
                    end
                end
            end
            rio_pkg::ST_RUN: begin
                if (estop_active || op_done) begin
                    next_state = rio_pkg::ST_RESET;
                end else if (cmd[rio_pkg::CMD_PAUSE]) begin
                    next_state = rio_pkg::ST_PAUSING;
                end
            end
            rio_pkg::ST_PAUSING: begin
                if (estop_active) begin
                    next_state = rio_pkg::ST_RESET;
                end else if (motion_stopped) begin
                    next_state = rio_pkg::ST_PAUSED;
                end
            end
            rio_pkg::ST_PAUSED: begin
                if (estop_active || cmd[rio_pkg::CMD_RESET]) begin
                    next_state = rio_pkg::ST_RESET;
                end else if (cmd[rio_pkg::CMD_START]) begin
                    next_state = rio_pkg::ST_RUN;
                end
            end
            default: next_state = rio_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= rio_pkg::ST_RESET;
            op    <= rio_pkg::OP_PROG;
        end else begin
            state <= next_state;
            op    <= next_op;
        end
    end

    // Program number is taken from the parallel remote when a program starts while the parallel remote is the chosen source
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prog <= rio_pkg::PROG_RESET_VAL;
        end else if (state == rio_pkg::ST_RESET && next_op == rio_pkg::OP_PROG
                     && next_state == rio_pkg::ST_RUN && par_ok) begin
            prog <= prog_sel;
        end
    end

    // Motor power, dropped by an emergency stop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            motor_on <= 1'b0;
        end else if (estop_active || (state == rio_pkg::ST_RESET && cmd[rio_pkg::CMD_MOFF])) begin
            motor_on <= 1'b0;
        end else if (state == rio_pkg::ST_RESET && cmd[rio_pkg::CMD_MON]) begin
            motor_on <= 1'b1;
        end
    end

    // Error latch; a new error wins over a reset in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            err <= 1'b0;
        end else if (error_event || (state == rio_pkg::ST_RESET && bad_motion)) begin
            err <= 1'b1;
        end else if (cmd[rio_pkg::CMD_RESET]) begin
            err <= 1'b0;
        end
    end

    // Status outputs, independent of mode and console choice
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reset       <= 1'b0;
            st_pause       <= 1'b0;
            st_run         <= 1'b0;
            st_home        <= 1'b0;
            st_prog        <= rio_pkg::PROG_RESET_VAL;
            st_cal         <= 1'b0;
            st_motor       <= 1'b0;
            st_error       <= 1'b0;
            st_estop       <= 1'b0;
            st_door        <= 1'b0;
            st_auto        <= 1'b0;
            st_teach       <= 1'b0;
            hold_exec      <= 1'b0;
            motor_power_en <= 1'b0;
        end else begin
            st_reset       <= state == rio_pkg::ST_RESET;
            st_pause       <= state == rio_pkg::ST_PAUSED;
            st_run         <= state == rio_pkg::ST_RUN;
            st_home        <= at_home;
            st_prog        <= prog;
            st_cal         <= state == rio_pkg::ST_RUN && op == rio_pkg::OP_CAL;
            st_motor       <= motor_on;
            st_error       <= err;
            st_estop       <= estop_active;
            st_door        <= door_open;
            st_auto        <= auto_mode;
            st_teach       <= teach_mode;
            hold_exec      <= state == rio_pkg::ST_PAUSING || state == rio_pkg::ST_PAUSED;
            motor_power_en <= motor_on;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_pause_taken;
        state == rio_pkg::ST_RUN && cmd[rio_pkg::CMD_PAUSE] && !estop_active && !op_done;
    endsequence

    sequence s_stop_seen;
        state == rio_pkg::ST_PAUSING && motion_stopped && !estop_active;
    endsequence

    a_reset_status: assert property (!rst && state == rio_pkg::ST_RESET |=> st_reset)
        else $error("reset status missing in reset state");
    a_pause_holds: assert property (s_pause_taken |-> ##2 hold_exec && !st_run)
        else $error("pause did not hold execution");
    a_pause_after_stop: assert property (s_stop_seen |-> ##2 st_pause)
        else $error("pause status late after stop");
    a_pause_needs_stop: assert property ($rose(st_pause) |-> $past(motion_stopped, 2))
        else $error("pause status before motion stopped");
    a_run_status: assert property (state == rio_pkg::ST_RUN |=> st_run && !st_reset)
        else $error("run status wrong while running");
    a_home_status: assert property (at_home |=> st_home)
        else $error("home status missing");
    a_prog_number: assert property (state == rio_pkg::ST_RESET && cmd[rio_pkg::CMD_START] && par_ok
        && !err && !estop_active |-> ##2 st_prog == $past(prog_sel, 2))
        else $error("program number not presented");
    a_cal_status: assert property (state == rio_pkg::ST_RUN && op == rio_pkg::OP_CAL |=> st_cal)
        else $error("calibration status missing");
    a_motor_on: assert property (state == rio_pkg::ST_RESET && cmd[rio_pkg::CMD_MON]
        && !cmd[rio_pkg::CMD_MOFF] && !estop_active |-> ##2 st_motor)
        else $error("motor status not on");
    a_error_sticky: assert property (err && !cmd[rio_pkg::CMD_RESET] |=> err)
        else $error("error cleared without reset");
    a_estop_status: assert property (estop_active |=> st_estop ##1 !st_motor)
        else $error("emergency stop status missing");
    a_unconfig_ignore: assert property (!ctrl[rio_pkg::CTRL_CONFIGURED] && ctrl[rio_pkg::CTRL_SOURCE]
        |-> cmd == '0)
        else $error("command taken from unconfigured remote");
    a_teach_reject: assert property (teach_mode |-> cmd == '0)
        else $error("command accepted in teach mode");
    a_auto_accept: assert property (console_ok && !ctrl[rio_pkg::CTRL_SOURCE] |-> cmd == opu_rise)
        else $error("chosen remote command dropped");
endmodule : rio_remote_status

// ===== rtl/rio_pkg.sv
// Constants shared by the remote I/O status and gating block
package rio_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_PROG   = 4'h8;
    // Control register fields
    localparam int CTRL_W          = 3;
    localparam int CTRL_CONFIGURED = 0;
    localparam int CTRL_SOURCE     = 1;
    localparam int CTRL_CONSOLE    = 2;
    localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
    // Pulsed command positions, shared by both remotes
    localparam int CMD_W     = 7;
    localparam int CMD_RESET = 0;
    localparam int CMD_PAUSE = 1;
    localparam int CMD_START = 2;
    localparam int CMD_HOME  = 3;
    localparam int CMD_CAL   = 4;
    localparam int CMD_MON   = 5;
    localparam int CMD_MOFF  = 6;
    localparam int PROG_W    = 4;
    localparam int STATUS_W  = 15;
    localparam logic [3:0] PROG_RESET_VAL = 4'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET   = 4'b0001,
        ST_RUN     = 4'b0010,
        ST_PAUSING = 4'b0100,
        ST_PAUSED  = 4'b1000
    } rio_state_t;
    // Operation under way while running
    typedef enum logic [2:0] {
        OP_PROG = 3'b001,
        OP_HOME = 3'b010,
        OP_CAL  = 3'b100
    } rio_op_t;
endpackage : rio_pkg

// ===== rtl/rio_reg_if.sv
// Register access carrier between the bus slave and the register file
`timescale 1ns/100ps
interface rio_reg_if;
    logic                       wr_en;
    logic [rio_pkg::ADDR_W-1:0] wr_addr;
    logic [rio_pkg::DATA_W-1:0] wr_data;
    logic [3:0]                 wr_strb;
    logic                       wr_ok;
    logic [rio_pkg::ADDR_W-1:0] rd_addr;
    logic [rio_pkg::DATA_W-1:0] rd_data;
    logic                       rd_ok;
    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : rio_reg_if

// ===== rtl/rio_sync_edge.sv
// Two-stage synchroniser with rising-edge detect
`timescale 1ns/100ps
module rio_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta  <= '0;
            level <= '0;
            prev  <= '0;
        end else begin
            meta  <= din;
            level <= meta;
            prev  <= level;
        end
    end

    assign rise = level & ~prev;
endmodule : rio_sync_edge

// ===== rtl/rio_axil_slave.sv
// AXI4-Lite slave front end for the register file
`timescale 1ns/100ps
module rio_axil_slave (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic [rio_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [rio_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [rio_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [rio_pkg::DATA_W-1:0]      rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    rio_reg_if.bus                          regs
);
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;

    assign wr_fire      = aw_held & w_held & ~bvalid;
    assign next_aw_held = aw_held ? ~wr_fire : (awvalid & awready);
    assign next_w_held  = w_held ? ~wr_fire : (wvalid & wready);
    assign next_bvalid  = wr_fire | (bvalid & ~bready);
    assign next_rvalid  = (arvalid & arready) | (rvalid & ~rready);
    assign regs.wr_en   = wr_fire;
    assign regs.rd_addr = araddr;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            awready      <= 1'b0;
            wready       <= 1'b0;
            regs.wr_addr <= '0;
            regs.wr_data <= '0;
            regs.wr_strb <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            awready <= ~next_aw_held & ~next_bvalid;
            wready  <= ~next_w_held & ~next_bvalid;
            if (awvalid && awready) begin
                regs.wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                regs.wr_data <= wdata;
                regs.wr_strb <= wstrb;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= rio_pkg::RESP_OKAY;
        end else begin
            bvalid <= next_bvalid;
            if (wr_fire) begin
                bresp <= regs.wr_ok ? rio_pkg::RESP_OKAY : rio_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid  <= 1'b0;
            arready <= 1'b0;
            rdata   <= '0;
            rresp   <= rio_pkg::RESP_OKAY;
        end else begin
            rvalid  <= next_rvalid;
            arready <= ~next_rvalid;
            if (arvalid && arready) begin
                rdata <= regs.rd_data;
                rresp <= regs.rd_ok ? rio_pkg::RESP_OKAY : rio_pkg::RESP_SLVERR;
            end
        end
    end
endmodule : rio_axil_slave

// ===== tb/rio_host_model.sv
// Host sequencer model driving both remotes' command lines
`timescale 1ns/100ps
module rio_host_model #(
    parameter int PW = 4
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       st_reset,
    input  wire logic       st_run,
    input  wire logic [7:0] req,
    output logic      [6:0] par_cmd,
    output logic      [6:0] opu_cmd
);
    int cnt;
    // Run-type commands wait for reset high and run low
    wire ok = (st_reset && !st_run) || (req[1:0] != 2'h0);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt     <= 0;
            par_cmd <= '0;
            opu_cmd <= '0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                par_cmd <= '0;
                opu_cmd <= '0;
            end
        end else if (req[6:0] != 7'h0 && ok) begin
            cnt     <= PW;
            par_cmd <= req[7] ? 7'h0 : req[6:0];
            opu_cmd <= req[7] ? req[6:0] : 7'h0;
        end
    end
endmodule : rio_host_model

// ===== tb/test_rio_remote_status.sv
// Self-checking bench for the remote I/O status and gating block
`timescale 1ns/100ps
module test_rio_remote_status;
    logic mclk = 1'b0;
    logic rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, auto_mode, teach_mode, estop_active;
    logic door_open, at_home, motion_stopped, op_done, error_event, st_reset, st_pause, st_run, st_home;
    logic st_cal, st_motor, st_error, st_estop, st_door, st_auto, st_teach, hold_exec, motor_power_en;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, par_prog, st_prog, prog;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] par_cmd, opu_cmd;
    logic [7:0] req;
    logic [33:0] exp_q[$];
    int error_cnt = 0, total_checks = 0, seed = 32'h675345EB;
    rio_remote_status dut_u (.*);
    rio_host_model #(.PW(4)) host_u (.mclk(mclk), .rst(rst), .st_reset(st_reset), .st_run(st_run),
                                     .req(req), .par_cmd(par_cmd), .opu_cmd(opu_cmd));
    initial forever #20 mclk = ~mclk;
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk({32'h0, s_axi_bresp}, {32'h0, r});
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [33:0] want);
        exp_q.push_back(want);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask : rd
    // Status word: flags above the program number
    task automatic rs(input logic [10:0] f);
        rd(rio_pkg::REG_STATUS, {19'h0, f, prog});
    endtask : rs
    task automatic cmd(input logic [7:0] v);
        req <= v;
        repeat (2) @(posedge mclk);
        req <= 8'h0;
        repeat (12) @(posedge mclk);
    endtask : cmd
    always @(posedge mclk) if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {auto_mode, teach_mode, estop_active, door_open, at_home, motion_stopped, op_done, error_event} = 8'h80;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, par_prog, req, prog} = {40'h0, 4'hF, 16'h0};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(rio_pkg::REG_CTRL, 34'h0);
        rs(11'h201);
        wr(rio_pkg::REG_CTRL, 32'h7, rio_pkg::RESP_OKAY);
        prog = 4'($random(seed));
        par_prog <= prog;
        cmd(8'h04);
        rs(11'h204);
        chk({30'h0, st_prog}, {30'h0, prog});
        cmd(8'h02);
        chk({33'h0, hold_exec}, 34'h1);
        chk({33'h0, st_pause}, 34'h0);
        motion_stopped <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({33'h0, st_pause}, 34'h1);
        cmd(8'h01);
        motion_stopped <= 1'b0;
        rs(11'h201);
        cmd(8'h20);
        rs(11'h221);
        chk({33'h0, motor_power_en}, 34'h1);
        cmd(8'h10);
        rs(11'h234);
        op_done <= 1'b1;
        @(posedge mclk);
        op_done <= 1'b0;
        repeat (3) @(posedge mclk);
        rs(11'h221);
        {door_open, at_home, error_event} <= 3'h7;
        @(posedge mclk);
        error_event <= 1'b0;
        repeat (4) @(posedge mclk);
        rs(11'h369);
        {auto_mode, teach_mode} <= 2'h1;
        cmd(8'h01);
        rs(11'h569);
        {auto_mode, teach_mode} <= 2'h2;
        wr(rio_pkg::REG_CTRL, 32'h5, rio_pkg::RESP_OKAY);
        cmd(8'h01);
        rs(11'h369);
        cmd(8'h81);
        rs(11'h329);
        // Home from the operating unit while motor power is on
        cmd(8'h88);
        rs(11'h32C);
        op_done <= 1'b1;
        @(posedge mclk);
        op_done <= 1'b0;
        repeat (3) @(posedge mclk);
        wr(rio_pkg::REG_CTRL, 32'h6, rio_pkg::RESP_OKAY);
        cmd(8'h40);
        rs(11'h329);
        estop_active <= 1'b1;
        repeat (4) @(posedge mclk);
        rs(11'h389);
        wr(4'hC, 32'h0, rio_pkg::RESP_SLVERR);
        rd(4'hC, {rio_pkg::RESP_SLVERR, 32'h0});
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        stop_test();
    end
endmodule : test_rio_remote_status
